// ---- src/receive_parallel_output_port.sv ----
/*
 * Receive parallel output port: a character buffer, the selected receive
 * interface clock (recovered or reference) and the output register for
 * data, status and odd parity, plus an APB register slave.
 * Assumes characters arrive from the framer/decoder on clk_sys with a
 * valid/ready handshake; reference_clock and reframe_allow come from pins.
 */
// Chosen here: the APB interface to the registers and the register offsets.

// ------------------------------------------------------------
// Character buffer
// ------------------------------------------------------------
module char_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 32,
   parameter int LVL_W = 6
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data,
   // Occupancy
   output logic [LVL_W-1:0]      level
);
   // Occupancy is counted, not derived from the pointers, so full and
   // empty need no wrap bit and the level is ready for software
   localparam int PTR_W = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wr_ptr_q;
   logic [PTR_W-1:0] rd_ptr_q;
   logic [LVL_W-1:0] count_q;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   // Ready tracks room only, never a pending pop
   assign in_ready  = (count_q != LVL_W'(DEPTH));
   assign out_valid = (count_q != '0);
   assign out_data  = mem_q[rd_ptr_q];
   assign level     = count_q;

   // No reset: only words below the count are ever read
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         count_q <= count_q + LVL_W'(push) - LVL_W'(pop);
      end
   end
endmodule : char_fifo

module receive_parallel_output_port (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Characters from framer and decoder
   input  wire logic        char_valid,
   output logic             char_ready,
   input  wire logic [9:0]  char_raw,
   input  wire logic [7:0]  char_decoded,
   input  wire logic [2:0]  char_status,
   input  wire logic [2:0]  char_status_alt,
   // Pins from outside
   input  wire logic        reference_clock,
   input  wire logic        reframe_allow,
   // Framer control
   output logic             framer_realign_en,
   // Parallel output to host
   output logic [7:0]       rx_data,
   output logic [2:0]       rx_char_status,
   output logic             rx_odd_parity_out,
   output logic             rx_odd_parity_oe,
   output logic             rx_char_clock_out,
   output logic             rx_char_clock_out_n,
   output logic             delayed_refclock_out,
   output logic             delayed_refclock_oe
);

   // ------------------------------------------------------------
   // Registers and bus decode
   // ------------------------------------------------------------
   // Read data and error are captured in the setup cycle
   logic [8:0]  ctrl_q;
   logic [15:0] period_q;
   logic        underrun_q;
   logic [31:0] prdata_q;
   logic        pslverr_q;

   // Zero wait states: every access ends in its first access cycle,
   // so read data must already stand when the access begins
   wire setup     = psel && !penable;
   wire access    = psel && penable;
   wire hit_ctrl  = (paddr == rx_port_pkg::OFS_CTRL);
   wire hit_stat  = (paddr == rx_port_pkg::OFS_STATUS);
   wire hit_undr  = (paddr == rx_port_pkg::OFS_UNDERRUN);
   wire hit_per   = (paddr == rx_port_pkg::OFS_PERIOD);
   wire unmapped  = !(hit_ctrl || hit_stat || hit_undr || hit_per);
   wire wr_ctrl   = access && pwrite && hit_ctrl;
   wire wr_undr   = access && pwrite && hit_undr && pwdata[0];
   wire wr_per    = access && pwrite && hit_per;

   // Select code 3 counts as neither low nor high
   wire [1:0] decode_select        = ctrl_q[rx_port_pkg::CTRL_DECODE_POS +: 2];
   wire [1:0] parity_control_sel   = ctrl_q[rx_port_pkg::CTRL_PARITY_POS +: 2];
   wire [1:0] rx_clock_source_sel  = ctrl_q[rx_port_pkg::CTRL_SOURCE_POS +: 2];
   wire [1:0] rx_status_mode_sel   = ctrl_q[rx_port_pkg::CTRL_MODE_POS +: 2];
   wire       rx_clock_rate_sel    = ctrl_q[rx_port_pkg::CTRL_RATE_POS];

   wire decoder_on = (decode_select != rx_port_pkg::SEL_LOW);
   wire parity_on  = (parity_control_sel != rx_port_pkg::SEL_LOW);
   wire ref_mode   = (rx_clock_source_sel == rx_port_pkg::SEL_LOW);

   // Error shows only in the access phase
   assign pready  = access;
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q && access;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   // Two flip-flops per pin before any logic looks at it; the later
   // stages of the clock chain feed the edge detector and delayed pin
   logic reference_clock_meta_q;
   logic reference_clock_sync_q;
   logic reference_clock_prev_q;
   logic reference_clock_dly_q;
   logic reframe_meta_q;
   logic reframe_sync_q;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         reference_clock_meta_q  <= 1'b0;
         reference_clock_sync_q  <= 1'b0;
         reference_clock_prev_q  <= 1'b0;
         reference_clock_dly_q   <= 1'b0;
         reframe_meta_q <= 1'b0;
         reframe_sync_q <= 1'b0;
      end else begin
         reference_clock_meta_q  <= reference_clock;
         reference_clock_sync_q  <= reference_clock_meta_q;
         reference_clock_prev_q  <= reference_clock_sync_q;
         reference_clock_dly_q   <= reference_clock_prev_q;
         reframe_meta_q <= reframe_allow;
         reframe_sync_q <= reframe_meta_q;
      end
   end

   // The framer sees only the synchronised level
   assign framer_realign_en = reframe_sync_q;

   // Pin edge as seen behind the synchroniser
   wire ref_rise = reference_clock_sync_q && !reference_clock_prev_q;

   // ------------------------------------------------------------
   // Recovered character clock
   // ------------------------------------------------------------
   // The half-period is the character period at full rate split in two,
   // and one full character period per level at half rate.
   logic [15:0] div_cnt_q;
   logic        rec_clk_q;
   logic        rate_prev_q;

   wire [15:0] half_len  = rx_clock_rate_sel ? period_q : {1'b0, period_q[15:1]};
   // A compare of at least, so a shorter period written mid-count
   // wraps at once instead of running to the counter's limit
   wire        div_wrap  = (div_cnt_q >= half_len - 16'h0001);
   wire        rate_chg  = (rx_clock_rate_sel != rate_prev_q);
   wire        rec_rise  = div_wrap && !rec_clk_q;
   wire        rec_fall  = div_wrap && rec_clk_q;
   // Half rate: the true rising edge and the complement rising edge each
   // take a character, so every level change is an update point.
   wire        rec_edge  = rx_clock_rate_sel ? div_wrap : rec_rise;
   wire        clk_event = ref_mode ? ref_rise : rec_edge;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         div_cnt_q   <= 16'h0000;
         rec_clk_q   <= 1'b0;
         rate_prev_q <= 1'b0;
      end else begin
         rate_prev_q <= rx_clock_rate_sel;
         // Restart the divider on a rate change so no short clock level
         // lands beside a data update.
         if (rate_chg) begin
            div_cnt_q <= 16'h0000;
            rec_clk_q <= 1'b0;
         end else if (div_wrap) begin
            div_cnt_q <= 16'h0000;
            rec_clk_q <= !rec_clk_q;
         end else begin
            div_cnt_q <= div_cnt_q + 16'h0001;
         end
      end
   end

   // ------------------------------------------------------------
   // Character buffer
   // ------------------------------------------------------------
   logic                             fifo_out_valid;
   logic [rx_port_pkg::CHAR_W-1:0]   fifo_out_data;
   logic [rx_port_pkg::LEVEL_W-1:0]  fifo_level;
   logic                             event_q;
   logic                             update_q;

   char_fifo #(
      .WIDTH (rx_port_pkg::CHAR_W),
      .DEPTH (rx_port_pkg::FIFO_DEPTH),
      .LVL_W (rx_port_pkg::LEVEL_W)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_valid  (char_valid),
      .in_ready  (char_ready),
      .in_data   ({char_status_alt, char_status, char_decoded, char_raw}),
      .out_valid (fifo_out_valid),
      .out_ready (update_q),
      .out_data  (fifo_out_data),
      .level     (fifo_level)
   );

   // ------------------------------------------------------------
   // Output register formatting
   // ------------------------------------------------------------
   // Zero padding leaves the parity of a narrower word unchanged
   function automatic logic odd_bit(logic [9:0] v);
      return ~(^v);
   endfunction : odd_bit

   // Buffer word, low to high: raw, decoded, status, alternate status
   wire [9:0] raw_w     = fifo_out_data[9:0];
   wire [7:0] dec_w     = fifo_out_data[17:10];
   wire [2:0] st_w      = fifo_out_data[20:18];
   wire [2:0] st_alt_w  = fifo_out_data[23:21];
   // Comma: the seven-bit 0011111 or 1100000 prefix in transmission order
   wire       comma_w   = (raw_w[9:3] == 7'h1F) || (raw_w[9:3] == 7'h60);
   // Status mode matters only with the decoder on
   wire [2:0] dec_st_w  = (rx_status_mode_sel == rx_port_pkg::SEL_HIGH) ? st_alt_w : st_w;
   wire [7:0] data_d    = decoder_on ? dec_w : raw_w[9:2];
   wire [2:0] status_d  = decoder_on ? dec_st_w
                                     : {comma_w, raw_w[1:0]};
   wire       parity_d  = decoder_on ? odd_bit({2'h0, data_d})
                                     : odd_bit({data_d, status_d[1:0]});

   logic [7:0] data_q;
   logic [2:0] status_q;
   logic       parity_q;
   logic       rclk_q;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         event_q  <= 1'b0;
         update_q <= 1'b0;
         data_q   <= 8'h00;
         status_q <= 3'h0;
         parity_q <= 1'b1;
         rclk_q   <= 1'b0;
      end else begin
         // The pin moves one cycle after the internal edge and the data one
         // cycle after the pin, so the host's capturing edge sees old data
         event_q  <= clk_event;
         update_q <= event_q;
         if (update_q && fifo_out_valid) begin
            data_q   <= data_d;
            status_q <= status_d;
            parity_q <= parity_d;
         end
         rclk_q <= ref_mode ? reference_clock_prev_q : rec_clk_q;
      end
   end

   // The parity pad sits outside and drives only while enabled;
   // the clock pair has no enable and is always driven
   assign rx_data              = data_q;
   assign rx_char_status       = status_q;
   assign rx_odd_parity_out    = parity_q;
   assign rx_odd_parity_oe     = parity_on;
   assign rx_char_clock_out    = rclk_q;
   assign rx_char_clock_out_n  = !rclk_q;
   assign delayed_refclock_out = reference_clock_dly_q && ref_mode;
   assign delayed_refclock_oe  = ref_mode;

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   // Bits 31:16 and 12:11 read as zero
   wire [31:0] status_word = {16'h0000, reframe_sync_q, fifo_out_valid, char_ready,
                              2'h0, fifo_level, rclk_q, parity_q, status_q};
   wire [31:0] rd_mux = hit_ctrl ? {23'h0, ctrl_q} :
                        hit_stat ? status_word :
                        hit_undr ? {31'h0, underrun_q} :
                        hit_per  ? {16'h0, period_q} : 32'h0000_0000;
   // Below the floor a half period would shrink to a cycle or less
   wire [15:0] per_wr = (pwdata[15:0] < rx_port_pkg::PERIOD_MIN) ? rx_port_pkg::PERIOD_MIN : pwdata[15:0];

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ctrl_q     <= rx_port_pkg::CTRL_RST;
         period_q   <= rx_port_pkg::PERIOD_RST;
         underrun_q <= 1'b0;
         prdata_q   <= 32'h0000_0000;
         pslverr_q  <= 1'b0;
      end else begin
         if (setup) begin
            prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_q <= unmapped || (pwrite && hit_stat);
         end
         if (wr_ctrl) begin
            ctrl_q <= pwdata[8:0];
         end
         if (wr_per) begin
            period_q <= per_wr;
         end
         // A missed character beats a clear in the same cycle
         if (update_q && !fifo_out_valid) begin
            underrun_q <= 1'b1;
         end else if (wr_undr) begin
            underrun_q <= 1'b0;
         end
      end
   end

endmodule : receive_parallel_output_port

// ---- src/rx_port_pkg.sv ----
/*
 * Constants for the receive parallel output port: select encodings,
 * register offsets, field positions, reset values and buffer sizes.
 * Assumes nothing of its surroundings; shared by every design file.
 */
package rx_port_pkg;

   // ------------------------------------------------------------
   // Three-level select encodings
   // ------------------------------------------------------------
   localparam logic [1:0] SEL_LOW  = 2'h0;
   localparam logic [1:0] SEL_MID  = 2'h1;
   localparam logic [1:0] SEL_HIGH = 2'h2;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [11:0] OFS_CTRL     = 12'h000;
   localparam logic [11:0] OFS_STATUS   = 12'h004;
   localparam logic [11:0] OFS_UNDERRUN = 12'h008;
   localparam logic [11:0] OFS_PERIOD   = 12'h00C;

   // ------------------------------------------------------------
   // Control register fields (bit positions)
   // ------------------------------------------------------------
   localparam int CTRL_DECODE_POS  = 0;   // [1:0]
   localparam int CTRL_PARITY_POS  = 2;   // [3:2]
   localparam int CTRL_SOURCE_POS  = 4;   // [5:4]
   localparam int CTRL_MODE_POS    = 6;   // [7:6]
   localparam int CTRL_RATE_POS    = 8;   // [8]
   localparam logic [8:0] CTRL_RST = 9'h015;   // decoder mid, parity mid, recovered clock

   // ------------------------------------------------------------
   // Recovered character period, in clk_sys cycles
   // ------------------------------------------------------------
   localparam logic [15:0] PERIOD_RST = 16'h000A;
   localparam logic [15:0] PERIOD_MIN = 16'h0004;

   // ------------------------------------------------------------
   // Character buffer
   // ------------------------------------------------------------
   localparam int FIFO_DEPTH = 32;
   localparam int CHAR_W     = 24;   // raw 10, decoded 8, status 3, alt status 3
   localparam int LEVEL_W    = 6;

endpackage : rx_port_pkg

// ---- tb/host_capture_model.sv ----
/* Host capture model: latches data, status and the parity pin on the host's capture edges.
   Assumes the bench tells it the clocking mode it has programmed. */
module host_capture_model (
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       rst_n,
   // Clocking mode
   input wire logic       ref_mode,
   input wire logic       half_rate,
   // Port pins
   input wire logic       clk_true,
   input wire logic       clk_comp,
   input wire logic       clk_delayed,
   input wire logic [7:0] data,
   input wire logic [2:0] status,
   input wire logic       parity_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] got[$];
   logic        true_q;
   logic        comp_q;
   logic        dly_q;
   wire logic   rise_true = clk_true && !true_q;
   wire logic   rise_comp = clk_comp && !comp_q;
   wire logic   rise_dly  = clk_delayed && !dly_q;
   // The edge that first sees a clock high still sees the word launched one update before
   always @(posedge clk_sys) begin
      true_q <= clk_true;
      comp_q <= clk_comp;
      dly_q  <= clk_delayed;
      if (rst_n && (ref_mode ? rise_dly : (rise_true || (half_rate && rise_comp)))) begin
         got.push_back({parity_pin, status, data});
      end
   end
endmodule : host_capture_model

// ---- tb/receive_parallel_output_port_properties.sv ----
/* Checker for the receive parallel output port: update timing, clock pair, parity, reframe sync, APB timing.
   Bound to the top module and sees its ports only. */
module rx_port_properties (
   // Clock, reset and bus
   input wire logic       clk_sys,
   input wire logic       rst_n,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       pslverr,
   // Port pins
   input wire logic       reframe_allow,
   input wire logic       framer_realign_en,
   input wire logic [7:0] rx_data,
   input wire logic [2:0] rx_char_status,
   input wire logic       rx_odd_parity_out,
   input wire logic       rx_char_clock_out,
   input wire logic       rx_char_clock_out_n,
   input wire logic       delayed_refclock_out,
   input wire logic       delayed_refclock_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ------------------------------------------------------------
   // Cycles since the receive clock last moved, saturating
   // ------------------------------------------------------------
   logic [7:0] since_tog_q;
   always_ff @(posedge clk_sys) begin
      if (!rst_n || $changed(rx_char_clock_out)) begin
         since_tog_q <= 8'h00;
      end else if (since_tog_q != 8'hFF) begin
         since_tog_q <= since_tog_q + 8'h01;
      end
   end
   // Data trails the clock pin by one cycle in either mode; a clock move just after the data is also accepted
   sequence s_clock_moves;
      ##[1:3] $changed(rx_char_clock_out);
   endsequence
   sequence s_sync_delay;
      !framer_realign_en ##[1:3] framer_realign_en;
   endsequence
   a_status_after_clock: assert property ($changed(rx_char_status) |-> (since_tog_q <= 8'h03) or s_clock_moves)
      else $error("status moved away from a receive clock edge");
   a_data_after_clock: assert property ($changed(rx_data) |-> (since_tog_q <= 8'h03) or s_clock_moves)
      else $error("data moved away from a receive clock edge");
   a_parity_is_odd: assert property ((rx_odd_parity_out == ~^rx_data) ||
      (rx_odd_parity_out == ~^{rx_data, rx_char_status[1:0]}))
      else $error("parity output is not odd");
   a_clock_pair_complement: assert property (rx_char_clock_out_n == !rx_char_clock_out)
      else $error("receive clocks are not complementary");
   a_delayed_needs_enable: assert property (delayed_refclock_out |-> delayed_refclock_oe)
      else $error("delayed clock active while disabled");
   a_clock_keeps_running: assert property (since_tog_q < 8'h40)
      else $error("receive clock stopped");
   a_reframe_synced: assert property ($rose(reframe_allow) && !framer_realign_en |=> s_sync_delay)
      else $error("reframe enable not synchronised in time");
   a_apb_zero_wait: assert property (pready == (psel && penable))
      else $error("ready outside the access phase");
   a_error_in_access: assert property (pslverr |-> psel && penable)
      else $error("error response outside the access phase");
endmodule : rx_port_properties

bind receive_parallel_output_port rx_port_properties u_props (
   .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .reframe_allow(reframe_allow), .framer_realign_en(framer_realign_en), .rx_data(rx_data),
   .rx_char_status(rx_char_status), .rx_odd_parity_out(rx_odd_parity_out), .rx_char_clock_out(rx_char_clock_out),
   .rx_char_clock_out_n(rx_char_clock_out_n), .delayed_refclock_out(delayed_refclock_out),
   .delayed_refclock_oe(delayed_refclock_oe));

// ---- tb/receive_parallel_output_port_tb.sv ----
/* Testbench for the receive parallel output port: APB master, character source, reference clock, host model.
   Assumes the design, the checker and the host model are compiled first. */
module receive_parallel_output_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        clk_sys, rst_n, psel, penable, pwrite, char_valid, reference_clock, reframe_allow;
   logic        pready, pslverr, char_ready, realign, par_out, par_oe, clk_out, clk_out_n, dly_clk, dly_oe;
   logic        host_ref, host_half, saw_full, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [9:0]  char_raw;
   logic [7:0]  char_decoded, rx_data;
   logic [2:0]  char_status, char_status_alt, rx_char_status;
   logic [11:0] exp_q[$];
   logic [8:0]  cfg_tab[5] = '{9'h014, 9'h115, 9'h092, 9'h149, 9'h110};
   int          seed = 32'h6cd2;
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          i, n;
   wire logic   parity_pin = par_oe ? par_out : 1'bz;

   receive_parallel_output_port u_receive_parallel_output_port (
      .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .char_valid(char_valid),
      .char_ready(char_ready), .char_raw(char_raw), .char_decoded(char_decoded), .char_status(char_status),
      .char_status_alt(char_status_alt), .reference_clock(reference_clock), .reframe_allow(reframe_allow),
      .framer_realign_en(realign), .rx_data(rx_data), .rx_char_status(rx_char_status),
      .rx_odd_parity_out(par_out), .rx_odd_parity_oe(par_oe), .rx_char_clock_out(clk_out),
      .rx_char_clock_out_n(clk_out_n), .delayed_refclock_out(dly_clk), .delayed_refclock_oe(dly_oe));
   host_capture_model u_host_capture_model (
      .clk_sys(clk_sys), .rst_n(rst_n), .ref_mode(host_ref), .half_rate(host_half), .clk_true(clk_out),
      .clk_comp(clk_out_n), .clk_delayed(dly_clk), .data(rx_data), .status(rx_char_status),
      .parity_pin(parity_pin));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // Free-running, phase unrelated to clk_sys
   initial begin
      reference_clock = 1'b0;
      #37;
      forever #80 reference_clock = ~reference_clock;
   end
   // ------------------------------------------------------------
   // Expectations, comparison and drivers
   // ------------------------------------------------------------
   function automatic logic [11:0] expect_word(logic [8:0] cfg, logic [9:0] r, logic [7:0] dv, logic [2:0] s,
                                               logic [2:0] a);
      logic [7:0] d;
      logic [2:0] st;
      logic       p;
      if (cfg[1:0] == 2'h0) begin
         d  = r[9:2];
         st = {(r[9:3] == 7'h1F) || (r[9:3] == 7'h60), r[1:0]};
         p  = ~^{d, st[1:0]};
      end else begin
         d  = dv;
         st = (cfg[7:6] == 2'h2) ? a : s;
         p  = ~^d;
      end
      return {(cfg[3:2] == 2'h0) ? 1'bz : p, st, d};
   endfunction : expect_word
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (!pready);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : apb
   // First word of a burst is the inverse of the last one, so the host trace can be aligned
   task automatic push(int cnt, logic [8:0] cfg);
      logic       ok;
      logic [9:0] r;
      logic [7:0] dv;
      logic [2:0] s, a;
      for (int k = 0; k < cnt; k++) begin
         r  = (k == 0) ? ~char_raw : (k == 1) ? 10'h0F8 : (k == 2) ? 10'h307 : 10'($random(seed));
         dv = (k == 0) ? ~char_decoded : 8'($random(seed));
         s  = (k == 0) ? ~char_status : 3'($random(seed));
         a  = (k == 0) ? ~char_status_alt : 3'($random(seed));
         char_raw        <= r;
         char_decoded    <= dv;
         char_status     <= s;
         char_status_alt <= a;
         char_valid      <= 1'b1;
         exp_q.push_back(expect_word(cfg, r, dv, s, a));
         do begin
            @(posedge clk_sys);
            ok = char_ready;
            saw_full |= !ok;
         end while (!ok);
      end
      char_valid <= 1'b0;
   endtask : push
   task automatic close_out();
      $display("mismatches %0d compared %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      {rst_n, psel, penable, pwrite, char_valid, reframe_allow, host_ref, host_half, saw_full} = '0;
      {paddr, pwdata, char_raw, char_decoded, char_status, char_status_alt} = '0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(negedge clk_sys);
      chk("reset data", 32'h0, {21'h0, rx_char_status, rx_data});
      chk("reset pins", 32'h6A, {25'h0, par_out, par_oe, clk_out, clk_out_n, dly_oe, char_ready, realign});
      @(posedge clk_sys);
      apb(1'b0, rx_port_pkg::OFS_CTRL, 32'h0);
      chk("ctrl reset", {23'h0, rx_port_pkg::CTRL_RST}, rd);
      apb(1'b0, rx_port_pkg::OFS_PERIOD, 32'h0);
      chk("period reset", {16'h0, rx_port_pkg::PERIOD_RST}, rd);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      apb(1'b1, rx_port_pkg::OFS_STATUS, 32'hFFFF);
      chk("status write error", 32'h1, {31'h0, err});
      apb(1'b1, rx_port_pkg::OFS_PERIOD, 32'h2);
      apb(1'b0, rx_port_pkg::OFS_PERIOD, 32'h0);
      chk("period floor", {16'h0, rx_port_pkg::PERIOD_MIN}, rd);
      apb(1'b1, rx_port_pkg::OFS_PERIOD, 32'h28);
      foreach (cfg_tab[c]) begin
         apb(1'b1, rx_port_pkg::OFS_CTRL, {23'h0, cfg_tab[c]});
         host_ref      <= (cfg_tab[c][5:4] == 2'h0);
         host_half     <= cfg_tab[c][8];
         reframe_allow <= c[0];
         @(negedge clk_sys);
         chk("parity enable", {31'h0, cfg_tab[c][3:2] != 2'h0}, {31'h0, par_oe});
         chk("delayed clock enable", {31'h0, cfg_tab[c][5:4] == 2'h0}, {31'h0, dly_oe});
         @(posedge clk_sys);
         u_host_capture_model.got.delete();
         exp_q.delete();
         push((c == 0) ? 40 : 12, cfg_tab[c]);
         do apb(1'b0, rx_port_pkg::OFS_STATUS, 32'h0); while (rd[14]);
         n = u_host_capture_model.got.size();
         while (u_host_capture_model.got.size() < n + 2) @(posedge clk_sys);
         i = 0;
         while (i < u_host_capture_model.got.size() && u_host_capture_model.got[i] !== exp_q[0]) i++;
         foreach (exp_q[k]) chk("host word", {20'h0, exp_q[k]}, {20'h0, u_host_capture_model.got[i + k]});
         apb(1'b0, rx_port_pkg::OFS_UNDERRUN, 32'h0);
         chk("underrun", 32'h1, rd);
         apb(1'b1, rx_port_pkg::OFS_UNDERRUN, 32'h1);
      end
      chk("buffer refused", 32'h1, {31'h0, saw_full});
      close_out();
   end
   initial begin
      #160000;
      n_mismatch++;
      close_out();
   end
endmodule : receive_parallel_output_port_tb
